// File: mpd_pkg.sv
// Package of constants and types for the match PWM DAC generator.
package mpd_pkg;
   // Counter and match width; covers periods above the 10-bit resolution.
   localparam int unsigned CNT_W       = 16;
   // Match channel count and PWM-capable outputs.
   localparam int unsigned N_MATCH     = 4;
   localparam int unsigned N_PWM       = 3;
   // Index of the channel that holds the period.
   localparam int unsigned PERIOD_IDX  = 3;
   // Reset values.
   localparam logic [15:0] PERIOD_RST  = 16'h0707;
   localparam logic [15:0] DUTY_RST    = 16'h0000;
   localparam logic [2:0]  PWM_EN_RST  = 3'h0;
   // Application figures for the configuring party.
   localparam int unsigned CLK_HZ      = 200000000;
   localparam int unsigned CARRIER_HZ  = 40000;
   localparam int unsigned MIN_PERIOD  = 1024;

   typedef logic [CNT_W-1:0] mpd_cnt_t;

   // Software side: duty values, period, PWM selects, run.
   typedef struct packed {
      mpd_cnt_t [N_PWM-1:0] duty;
      mpd_cnt_t             period;
      logic [N_PWM-1:0]     pwm_en;
      logic                 run;
   } mpd_cfg_t;

   // Module state apart from the capture flops.
   typedef struct packed {
      mpd_cnt_t             cnt;
      mpd_cnt_t [N_PWM-1:0] duty_act;
      mpd_cnt_t             period_act;
      logic [N_PWM-1:0]     en_act;
      logic [N_MATCH-1:0]   match_output_n;
      logic                 wrap;
   } mpd_state_t;
endpackage : mpd_pkg

// File: mpd_generator.sv
// Match-based PWM generator used as a low-cost DAC.
//
// How it works
// [R1] Four match values drive four match outputs and four capture inputs latch the counter.
// [R2] In PWM mode the last match channel holds the period instead of a PWM output.
// [R3] Match outputs 2 to 0 can each be chosen individually for single-edge PWM.
// [R4] A counter equal to an enabled duty match value drives that output high; here a duty equal to the period never sets it, so it stays low.
// [R5] A match on the period value resets the counter to zero.
// [R6] When the counter returns to zero every PWM output that is high is cleared.
// [R7] Software chooses duty steps of one part in 1024 of the period.
// [R8] Software programs a period count above 1024 at the counting clock.
// [R9] Software sets the carrier to 40 kHz.
// [R10] New duty, period and select values take effect at the next wrap.
`timescale 1ns/100ps
module mpd_generator (
   // Clock and reset
   input  wire logic                 clk,
   input  wire logic                 nrst,
   // Configuration from software
   input  wire mpd_pkg::mpd_cfg_t    cfg,
   // Capture inputs, asynchronous pins
   input  wire logic [3:0]           capture_pin,
   // Outputs
   output logic [3:0]                match_output_n,
   output mpd_pkg::mpd_cnt_t [3:0]   capture_value_q,
   output logic                      wrap_q
);

   mpd_pkg::mpd_state_t s_q;
   mpd_pkg::mpd_state_t s_d;
   logic [3:0]          sync1_q;
   logic [3:0]          sync2_q;
   logic [3:0]          sync3_q;
   logic [3:0]          cap_lvl_q;

   // Capture pins: three flops, change counts once stages two and three agree.
   // The level starts low like an idle pin, so no false edge follows reset.
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         sync1_q         <= 4'h0;
         sync2_q         <= 4'h0;
         sync3_q         <= 4'h0;
         cap_lvl_q       <= 4'h0;
         capture_value_q <= '0;
      end
      else
      begin
         sync1_q <= capture_pin;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
         for (int i = 0; i < 4; i++)
         begin
            if (sync2_q[i] == sync3_q[i])
            begin
               cap_lvl_q[i] <= sync3_q[i];
               if (sync3_q[i] && !cap_lvl_q[i])
               begin
                  capture_value_q[i] <= s_q.cnt; // [R1]
               end
            end
         end
      end
   end

   always_comb
   begin
      logic at_period;
      s_d       = s_q;
      at_period = 1'b0;
      s_d.wrap  = 1'b0;
      if (cfg.run)
      begin
         at_period = (s_q.cnt == s_q.period_act); // [R2]
         if (at_period)
         begin
            s_d.cnt  = '0; // [R5]
            s_d.wrap = 1'b1;
            // Shadow values load only here, so a cycle is never mixed.
            s_d.duty_act   = cfg.duty; // [R10]
            s_d.period_act = cfg.period; // [R10]
            s_d.en_act     = cfg.pwm_en; // [R10]
            for (int i = 0; i < mpd_pkg::N_PWM; i++)
            begin
               s_d.match_output_n[i] = 1'b0; // [R6]
            end
         end
         else
         begin
            // A duty at or above the period never matches, so it stays low.
            s_d.cnt = mpd_pkg::CNT_W'(s_q.cnt + 1'b1);
            for (int i = 0; i < mpd_pkg::N_PWM; i++)
            begin
               if (s_q.en_act[i] && s_q.cnt == s_q.duty_act[i])
               begin
                  s_d.match_output_n[i] = 1'b1; // [R3] [R4]
               end
            end
         end
         // The period channel toggles on its match as an ordinary output.
         s_d.match_output_n[mpd_pkg::PERIOD_IDX] =
            s_q.match_output_n[mpd_pkg::PERIOD_IDX] ^ at_period; // [R1]
      end
   end

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         // Reset loads shadow values that the first wrap will replace.
         s_q.cnt            <= '0;
         s_q.duty_act       <= {mpd_pkg::N_PWM{mpd_pkg::DUTY_RST}};
         s_q.period_act     <= mpd_pkg::PERIOD_RST;
         s_q.en_act         <= mpd_pkg::PWM_EN_RST;
         s_q.match_output_n <= 4'h0;
         s_q.wrap           <= 1'b0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign match_output_n = s_q.match_output_n;
   assign wrap_q         = s_q.wrap;

   a_period_reset: assert property (@(posedge clk) disable iff (!nrst) // [R5]
      cfg.run && s_q.cnt == s_q.period_act |=> s_q.cnt == '0 && s_q.wrap)
      else $error("counter did not reset on period match");
   a_pwm_set_high: assert property (@(posedge clk) disable iff (!nrst) // [R4]
      cfg.run && s_q.cnt != s_q.period_act && s_q.en_act[0]
      && s_q.cnt == s_q.duty_act[0] |=> match_output_n[0])
      else $error("pwm output 0 not set on match");
   a_wrap_clears: assert property (@(posedge clk) disable iff (!nrst) // [R6]
      s_q.wrap |-> match_output_n[2:0] == 3'h0)
      else $error("pwm outputs not cleared at wrap");
   a_disabled_low: assert property (@(posedge clk) disable iff (!nrst) // [R3]
      s_q.wrap && !s_q.en_act[1] |-> !match_output_n[1] throughout
      (!s_q.wrap [*1] ##1 1'b1))
      else $error("unselected output went high");
   a_shadow_load: assert property (@(posedge clk) disable iff (!nrst) // [R10]
      !s_q.wrap && !$past(s_q.wrap) |-> $stable(s_q.duty_act))
      else $error("duty changed away from wrap");
   a_high_holds: assert property (@(posedge clk) disable iff (!nrst) // [R4]
      cfg.run && match_output_n[2] && s_q.cnt != s_q.period_act
      |=> match_output_n[2])
      else $error("pwm output dropped before wrap");
   a_period_chan: assert property (@(posedge clk) disable iff (!nrst) // [R2]
      s_q.wrap |-> match_output_n[3] != $past(match_output_n[3]))
      else $error("period channel did not toggle");
   a_count_step: assert property (@(posedge clk) disable iff (!nrst) // [R5]
      cfg.run && s_q.cnt != s_q.period_act
      |=> s_q.cnt == $past(s_q.cnt) + 16'h0001)
      else $error("counter did not step");

   // Outputs 0 and 1 follow the same set and hold rules as output 2.
   a_out1_set: assert property (@(posedge clk) disable iff (!nrst) // [R4]
      cfg.run && s_q.cnt != s_q.period_act && s_q.en_act[1]
      && s_q.cnt == s_q.duty_act[1] |=> match_output_n[1])
      else $error("pwm output 1 not set on match");
   a_out2_set: assert property (@(posedge clk) disable iff (!nrst) // [R4]
      cfg.run && s_q.cnt != s_q.period_act && s_q.en_act[2]
      && s_q.cnt == s_q.duty_act[2] |=> match_output_n[2])
      else $error("pwm output 2 not set on match");
   a_out0_holds: assert property (@(posedge clk) disable iff (!nrst) // [R4]
      cfg.run && match_output_n[0] && s_q.cnt != s_q.period_act
      |=> match_output_n[0])
      else $error("pwm output 0 dropped before wrap");
   a_out1_holds: assert property (@(posedge clk) disable iff (!nrst) // [R4]
      cfg.run && match_output_n[1] && s_q.cnt != s_q.period_act
      |=> match_output_n[1])
      else $error("pwm output 1 dropped before wrap");

   // A stopped counter holds its count and every match output.
   a_stop_freeze: assert property (@(posedge clk) disable iff (!nrst) // [R5]
      !cfg.run |=> $stable(s_q.cnt) && $stable(match_output_n))
      else $error("stopped counter moved");
   a_cnt_bound: assert property (@(posedge clk) disable iff (!nrst) // [R5]
      s_q.cnt <= s_q.period_act)
      else $error("counter passed the period");
   a_wrap_source: assert property (@(posedge clk) disable iff (!nrst) // [R5]
      s_q.wrap |-> $past(cfg.run)
      && $past(s_q.cnt) == $past(s_q.period_act))
      else $error("wrap without a period match");

   // Shadow period and selects move only in the wrap cycle.
   a_shadow_period: assert property (@(posedge clk) disable iff (!nrst) // [R10]
      !s_q.wrap |-> $stable(s_q.period_act))
      else $error("period changed away from wrap");
   a_shadow_select: assert property (@(posedge clk) disable iff (!nrst) // [R10]
      !s_q.wrap |-> $stable(s_q.en_act))
      else $error("selects changed away from wrap");

   // An unselected output never rises, and the period channel moves at wraps.
   a_unselected_low: assert property (@(posedge clk) disable iff (!nrst) // [R3]
      !s_q.en_act[2] && !match_output_n[2] |=> !match_output_n[2])
      else $error("unselected output 2 went high");
   a_period_still: assert property (@(posedge clk) disable iff (!nrst) // [R2]
      !s_q.wrap |-> $stable(match_output_n[3]))
      else $error("period channel moved away from wrap");

   // Capture latches once per rising pin and holds otherwise.
   a_capture_latch: assert property (@(posedge clk) disable iff (!nrst) // [R1]
      sync2_q[0] && sync3_q[0] && !cap_lvl_q[0]
      |=> capture_value_q[0] == $past(s_q.cnt))
      else $error("capture did not latch the count");
   a_capture_hold: assert property (@(posedge clk) disable iff (!nrst) // [R1]
      !(sync2_q[0] && sync3_q[0] && !cap_lvl_q[0])
      |=> $stable(capture_value_q[0]))
      else $error("capture value changed without an edge");

   c_wrap: cover property (@(posedge clk) disable iff (!nrst) s_q.wrap);
   c_pwm_high: cover property (@(posedge clk) disable iff (!nrst)
      match_output_n[0] ##1 s_q.wrap);
   c_all_high: cover property (@(posedge clk) disable iff (!nrst)
      match_output_n[2:0] == 3'h7);
   // Capture edges and a held stop are the remaining scenarios to see.
   c_capture: cover property (@(posedge clk) disable iff (!nrst)
      sync2_q[0] && sync3_q[0] && !cap_lvl_q[0]);
   c_stopped: cover property (@(posedge clk) disable iff (!nrst)
      !cfg.run ##1 !cfg.run);
endmodule : mpd_generator

// File: mpd_rc_filter.sv
// Behavioural RC stage: high-time of one PWM output per carrier cycle.
`timescale 1ns/100ps
module mpd_rc_filter (
   // Clock and framing
   input  wire logic         clk,
   input  wire logic         wrap,
   // Carrier in, averaged level out
   input  wire logic         pwm,
   output mpd_pkg::mpd_cnt_t level_q
);
   mpd_pkg::mpd_cnt_t acc_q;
   always_ff @(posedge clk)
   begin
      if (wrap)
      begin
         level_q <= acc_q;
         acc_q   <= {15'h0, pwm};
      end
      else
         acc_q <= acc_q + {15'h0, pwm};
   end
endmodule : mpd_rc_filter

// File: mpd_generator_tb.sv
// Self-checking bench for the match PWM DAC generator.
`timescale 1ns/100ps
module mpd_generator_tb;
   localparam logic [15:0] PER = 16'h044c; // 1100, above 1024
   logic              clk = 1'b0;
   logic              nrst = 1'b0;
   mpd_pkg::mpd_cfg_t cfg = '0;
   logic [3:0]        outs;
   logic              wrap_q;
   mpd_pkg::mpd_cnt_t level_q;
   logic [3:0]        cap_pin = 4'h0;
   mpd_pkg::mpd_cnt_t [3:0] cap_val;
   int                failures = 0;
   int                n_checks = 0;
   mpd_generator mpd_generator_i (.clk(clk), .nrst(nrst), .cfg(cfg),
      .capture_pin(cap_pin), .match_output_n(outs), .capture_value_q(cap_val),
      .wrap_q(wrap_q));
   mpd_rc_filter mpd_rc_filter_i (.clk(clk), .wrap(wrap_q), .pwm(outs[0]),
      .level_q(level_q));
   task automatic check(string what, logic [15:0] exp, logic [15:0] got);
      n_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic wrap_up;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : wrap_up
   // Returns clocks waited until the next wrap pulse.
   task automatic next_wrap(output int n);
      n = 0;
      do
      begin
         @(posedge clk);
         #1;
         n++;
      end while (wrap_q !== 1'b1 && n < 5000);
   endtask : next_wrap
   // New settings land at a wrap, so two wraps give one clean cycle.
   task automatic setup(logic [15:0] d, logic [2:0] en);
      int n;
      @(posedge clk);
      cfg <= '{duty: {3{d}}, period: PER, pwm_en: en, run: 1'b1};
      next_wrap(n);
      next_wrap(n);
   endtask : setup
   task automatic t_duty(logic [15:0] d, logic [15:0] hi);
      int n;
      setup(d, 3'h7);
      next_wrap(n);
      check("cycle length", PER + 16'h1, n[15:0]);
      @(posedge clk);
      #1;
      check("high time", hi, level_q);
      $display("duty %h done", d);
   endtask : t_duty
   task automatic t_glitch;
      int n;
      setup(16'h0100, 3'h7);
      repeat (200) @(posedge clk);
      cfg.duty <= {3{16'h0300}};
      next_wrap(n);
      @(posedge clk);
      #1;
      check("unchanged cycle", PER - 16'h0100, level_q);
      next_wrap(n);
      @(posedge clk);
      #1;
      check("updated cycle", PER - 16'h0300, level_q);
      $display("mid-cycle update done");
   endtask : t_glitch
   task automatic t_select;
      int n;
      setup(16'h0100, 3'h2);
      repeat (300) @(posedge clk);
      #1;
      check("selected outputs", 16'h2, {13'h0, outs[2:0]});
      $display("select done");
   endtask : t_select
   // Pin rises at E0; three flops later the count of cycle 4 is latched.
   task automatic t_capture;
      setup(16'h0100, 3'h7);
      @(posedge clk);
      cap_pin <= 4'h1;
      repeat (4) @(posedge clk);
      #1;
      check("capture value 0", 16'h0004, cap_val[0]);
      check("capture value 1", 16'h0000, cap_val[1]);
      @(posedge clk);
      cap_pin <= 4'h0;
      $display("capture done");
   endtask : t_capture
   task automatic t_stop;
      logic [3:0] held;
      int         seen;
      seen = 0;
      @(posedge clk);
      cfg.run <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      held = outs;
      repeat (2000)
      begin
         @(posedge clk);
         #1;
         seen += (wrap_q === 1'b1);
      end
      check("stopped outputs", {12'h0, held}, {12'h0, outs});
      check("stopped wraps", 16'h0, seen[15:0]);
      $display("stop done");
   endtask : t_stop
   initial
   begin
      forever #2.5 clk = ~clk;
   end
   initial
   begin
      #500000;
      failures++;
      wrap_up();
   end
   initial
   begin
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      t_duty(16'h0000, PER);
      t_duty(16'h0100, PER - 16'h0100);
      t_duty(PER - 16'h1, 16'h1);
      t_duty(PER, 16'h0);
      t_duty(PER + 16'h5, 16'h0);
      t_glitch();
      t_select();
      t_capture();
      t_stop();
      wrap_up();
   end
endmodule : mpd_generator_tb
